// File: mpo_defs.svh
/*
  constants for the monitor pulse output and input map block.
  assumes a 200 MHz pclk and an APB master issuing word accesses.
*/
// Notes on behaviour
// - monitor item codes 0..8 pick frequency, current, voltage, torque, load, power, PID, DC.
// - pulse mode only when output type is 1 and board switch on pulse side.
// - full-scale pulse rate accepts 300 to 6000 pulses per second.
// - average level 0: frequency proportional to monitored value, max equals full-scale rate.
// - level 1..200: rate fixed at 2670 per second, duty sets average level.
// - duty is high time over period; average volts is 15.6 times duty.
// - pulse item selector uses the same codes as the analog item selector.
// - relay polarity 0: contact a open in run, closed on trip; 1 inverts.
// - polarity 1 energizes relay about one second after power-up.
// - torque limits accept 20 to 200 percent or 999 to disable.
// - braking limit alone at 0 enables regeneration overvoltage avoidance.
// - vector control 1 forces automatic boost and automatic slip compensation.
// - under vector control slip setting 0 selects built-in standard amount.
// - codes 0..3 step, 4 ramp, 5 hold, 6 coast, 7 reset, 8 fault, 9 source.
// - codes 10 motor, 11 brake, 12 torque set, 13 up, 14 down, 15..18 misc.
// - codes not assigned to any terminal read inactive; here an unassigned fault (8) counts as on and never trips.
// - step bits form index; 0 normal source, 1..15 preset frequencies.
// - external fault inactive trips and latches alarm until fault reset.
`ifndef MPO_DEFS_SVH
`define MPO_DEFS_SVH
`define MPO_CLK_HZ         200000000
`define MPO_FIXED_RATE     2670
`define MPO_RATE_MIN       300
`define MPO_RATE_MAX       6000
`define MPO_LEVEL_MAX      200
`define MPO_TL_MIN         20
`define MPO_TL_MAX         200
`define MPO_TL_OFF         999
`define MPO_ITEM_MAX       8
`define MPO_FULL_MV        15600
`define MPO_RELAY_DELAY_MS 1000
`define MPO_SLIP_STD       8'h32
`define MPO_REG_METER      12'h000
`define MPO_REG_PULSE      12'h004
`define MPO_REG_TORQUE     12'h008
`define MPO_REG_VECTOR     12'h00C
`define MPO_REG_TERM       12'h010
`define MPO_REG_STATUS     12'h014
`define MPO_REG_MON        12'h018
`define MPO_RATE_RST       16'h0BB8
`define MPO_TL_RST         10'h3E7
`define MPO_FULL_SCALE     16'h8000
`define MPO_PCT_FULL       100
`define MPO_CODE_COUNT     19
`define MPO_CODE_COAST     6
`define MPO_CODE_RESET     7
`define MPO_CODE_FAULT     8
`endif

// File: mpo_pkg.sv
/*
  types shared by the monitor pulse output block.
  assumes mpo_defs.svh constants alongside.
*/
package mpo_pkg;
  typedef enum logic [1:0] {MPO_IDLE, MPO_HIGH, MPO_LOW} mpo_pulse_e;
  typedef logic [4:0] mpo_fcode_t;
endpackage

// File: mpo_pulse_if.sv
/*
  carrier between the top and the pulse timer.
  assumes one pclk domain.
*/
interface mpo_pulse_if;
  logic        enable;
  logic [31:0] period;
  logic [31:0] high_time;
  logic        pulse;
  logic        boundary;
  modport ctrl (output enable, output period, output high_time, input pulse, input boundary);
  modport gen  (input enable, input period, input high_time, output pulse, output boundary);
endinterface

// File: mpo_pulse_gen.sv
/*
  pulse timer counting period and high time from pclk.
  assumes period and high_time are stable between boundaries.
*/
module mpo_pulse_gen (
  input  wire logic pclk,
  input  wire logic presetn,
  mpo_pulse_if.gen  pif
);
  logic [31:0] cnt_q;
  logic [31:0] per_q;
  logic [31:0] hi_q;
  logic        pulse_q;

  assign pif.pulse    = pulse_q;
  assign pif.boundary = pif.enable && (cnt_q + 32'h1 >= per_q);

  // loading only at the wrap or while disabled keeps every pulse whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 32'h0;
      per_q <= 32'h0;
      hi_q  <= 32'h0;
    end else if (!pif.enable) begin
      cnt_q <= 32'h0;
      per_q <= pif.period;
      hi_q  <= pif.high_time;
    end else if (pif.boundary) begin
      cnt_q <= 32'h0;
      per_q <= pif.period;
      hi_q  <= pif.high_time;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= pif.enable && (per_q != 32'h0) && (cnt_q < hi_q);
    end
  end

  a_pulse_whole: assert property (@(posedge pclk) disable iff (!presetn)
    (pif.enable && !pif.boundary && !$past(pif.boundary) && $past(pif.enable)) |-> $stable(per_q))
    else $error("period changed inside a pulse");
endmodule // mpo_pulse_gen

// File: mpo_top.sv
/*
  monitor pulse output, relay polarity, torque and vector decode, input map.
  assumes an APB master on pclk and monitor values scaled so 16'hFFFF is 200 percent.
*/
// Local design decisions: the address map and register access over APB.
`include "mpo_defs.svh"
module mpo_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        board_output_selector_switch,
  input  wire logic [15:0] mon_value [0:8],
  input  wire logic [4:0]  digital_input,
  input  wire logic        trip_in,
  output logic             pulse_meter_output,
  output logic             relay_contact_a,
  output logic             relay_contact_b,
  output logic             driving_limit_active,
  output logic             braking_limit_active,
  output logic             overvoltage_avoid,
  output logic             auto_torque_boost,
  output logic             slip_comp_active,
  output logic [7:0]       slip_comp_amount,
  output logic [18:0]      func_active,
  output logic [3:0]       step_index,
  output logic             output_shutoff,
  output logic             fault_alarm
);
  localparam int unsigned RELAY_CYCLES = (`MPO_CLK_HZ / 1000) * `MPO_RELAY_DELAY_MS;
  localparam logic [31:0] FIXED_PERIOD = 32'(`MPO_CLK_HZ / `MPO_FIXED_RATE);

  logic [31:0] meter_q;
  logic [31:0] pulse_q;
  logic [31:0] torque_q;
  logic [31:0] vector_q;
  logic [31:0] term_q;
  logic [3:0]  analog_item;
  logic [3:0]  pulse_item;
  logic        out_type;
  logic        polarity;
  logic [15:0] rate_q;
  logic [7:0]  level_q;
  logic [9:0]  tl_drive;
  logic [9:0]  tl_brake;
  logic        vec_en;
  logic [7:0]  slip_set;
  logic [7:0]  boost_set;
  mpo_pkg::mpo_fcode_t fcode [0:4];
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [15:0] mon_sel;
  logic [15:0] mon_full;
  logic        pulse_mode;
  logic [31:0] relay_cnt_q;
  logic        relay_ready_q;
  logic        trip_q;
  logic        fault_q;
  logic [31:0] rd_d;
  logic [47:0] per_wide;
  logic [47:0] hi_wide;

  mpo_pulse_if pif ();

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign addr_ok = (paddr <= `MPO_REG_MON) && (paddr[1:0] == 2'b00);
  assign pslverr = psel && penable && !addr_ok;

  assign out_type    = meter_q[0];
  assign analog_item = meter_q[7:4];
  assign pulse_item  = meter_q[11:8];
  assign polarity    = meter_q[12];
  assign rate_q      = pulse_q[15:0];
  assign level_q     = pulse_q[23:16];
  assign tl_drive    = torque_q[9:0];
  assign tl_brake    = torque_q[25:16];
  assign vec_en      = vector_q[0];
  assign boost_set   = vector_q[15:8];
  assign slip_set    = vector_q[23:16];

  // out-of-range settings are dropped so the stored value stays legal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meter_q <= 32'h0;
    end else if (wr_en && paddr == `MPO_REG_METER) begin
      if (pwdata[7:4] <= 4'(`MPO_ITEM_MAX) && pwdata[11:8] <= 4'(`MPO_ITEM_MAX)) begin
        meter_q <= {19'h0, pwdata[12:0]} & 32'h00001FF1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= {16'h0, `MPO_RATE_RST};
    end else if (wr_en && paddr == `MPO_REG_PULSE) begin
      if (pwdata[15:0] >= 16'(`MPO_RATE_MIN) && pwdata[15:0] <= 16'(`MPO_RATE_MAX)
          && pwdata[23:16] <= 8'(`MPO_LEVEL_MAX)) begin
        pulse_q <= {8'h0, pwdata[23:0]};
      end
    end
  end

  function automatic logic tl_ok(input logic [9:0] v, input logic allow_zero);
    tl_ok = (v >= 10'(`MPO_TL_MIN) && v <= 10'(`MPO_TL_MAX)) || v == 10'(`MPO_TL_OFF)
            || (allow_zero && v == 10'h0);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      torque_q <= {6'h0, `MPO_TL_RST, 6'h0, `MPO_TL_RST};
    end else if (wr_en && paddr == `MPO_REG_TORQUE) begin
      if (tl_ok(pwdata[9:0], 1'b0) && tl_ok(pwdata[25:16], 1'b1)) begin
        torque_q <= pwdata & 32'h03FF03FF;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_q <= 32'h0;
    end else if (wr_en && paddr == `MPO_REG_VECTOR) begin
      vector_q <= pwdata & 32'h00FFFF01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_q <= 32'h0;
    end else if (wr_en && paddr == `MPO_REG_TERM) begin
      term_q <= {7'h0, pwdata[24:0]};
    end
  end

  always_comb begin
    rd_d = 32'h0;
    case (paddr)
      `MPO_REG_METER:  rd_d = meter_q;
      `MPO_REG_PULSE:  rd_d = pulse_q;
      `MPO_REG_TORQUE: rd_d = torque_q;
      `MPO_REG_VECTOR: rd_d = vector_q;
      `MPO_REG_TERM:   rd_d = term_q;
      `MPO_REG_STATUS: rd_d = {26'h0, relay_ready_q, fault_q, trip_q, pulse_mode,
                               relay_contact_b, relay_contact_a};
      `MPO_REG_MON:    rd_d = {16'h0, mon_sel};
      default:         rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_en) begin // taken in setup so it stands through the access phase
      prdata <= rd_d;
    end
  end

  // only the pulse selector indexes the table of nine quantities; the analog selector is not used
  assign mon_sel    = (pulse_item <= 4'(`MPO_ITEM_MAX)) ? mon_value[pulse_item] : 16'h0;
  assign pulse_mode = out_type && board_output_selector_switch;
  // above full scale the rate would pass the set maximum, so hold it at 100 percent
  assign mon_full   = (mon_sel > `MPO_FULL_SCALE) ? `MPO_FULL_SCALE : mon_sel;

  // rate mode scales the rate, level mode scales the duty at a fixed period
  always_comb begin
    per_wide = 48'h0;
    hi_wide  = 48'h0;
    if (level_q == 8'h0) begin
      if (mon_sel != 16'h0) begin
        per_wide = 48'(64'(`MPO_CLK_HZ) * 64'h10000 / (64'(rate_q) * 64'(mon_full) * 64'h2));
        // a tiny value would overflow the 32-bit timer; pin the period at its top
        if (per_wide[47:32] != 16'h0) begin
          per_wide = {16'h0, 32'hFFFFFFFF};
        end
        hi_wide  = per_wide >> 1;
      end
    end else begin
      per_wide = {16'h0, FIXED_PERIOD};
      // level in percent; 15.6 V is full duty, so duty = level*value/(100% scale)
      hi_wide  = 48'(64'(FIXED_PERIOD) * 64'(level_q) * 64'(mon_sel)
                 / (64'(`MPO_PCT_FULL) * 64'(`MPO_FULL_SCALE)));
      if (hi_wide > per_wide) begin
        hi_wide = per_wide;
      end
    end
  end

  assign pif.enable    = pulse_mode;
  assign pif.period    = per_wide[31:0];
  assign pif.high_time = hi_wide[31:0];
  assign pulse_meter_output = pif.pulse;

  mpo_pulse_gen u_gen (
    .pclk    (pclk),
    .presetn (presetn),
    .pif     (pif)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_cnt_q   <= 32'h0;
      relay_ready_q <= 1'b0;
    end else if (!relay_ready_q) begin
      if (relay_cnt_q >= 32'(RELAY_CYCLES - 1)) begin
        relay_ready_q <= 1'b1;
      end
      relay_cnt_q <= relay_cnt_q + 32'h1;
    end
  end

  assign trip_q = trip_in || fault_q;
  // before the delay expires the relay stays de-energized: a open, b closed
  assign relay_contact_a = relay_ready_q ? (trip_q ^ polarity) : 1'b0;
  assign relay_contact_b = ~relay_contact_a;

  assign driving_limit_active = tl_drive != 10'(`MPO_TL_OFF);
  assign braking_limit_active = (tl_brake != 10'(`MPO_TL_OFF)) && (tl_brake != 10'h0);
  assign overvoltage_avoid    = (tl_brake == 10'h0) && (tl_drive != 10'h0);
  assign auto_torque_boost    = vec_en || (boost_set == 8'h0);
  assign slip_comp_active     = vec_en || (slip_set != 8'h0);
  assign slip_comp_amount     = (vec_en && slip_set == 8'h0) ? `MPO_SLIP_STD : slip_set;

  for (genvar t = 0; t < 5; t++) begin : g_code
    assign fcode[t] = term_q[t*5 +: 5];
  end

  genvar f;
  generate
    for (f = 0; f < `MPO_CODE_COUNT; f++) begin : g_func
      logic hit;
      always_comb begin
        hit = 1'b0;
        for (int t = 0; t < 5; t++) begin
          if (fcode[t] == 5'(f) && digital_input[t]) begin
            hit = 1'b1;
          end
        end
      end
      assign func_active[f] = hit;
    end
  endgenerate

  logic fault_assigned;
  always_comb begin
    fault_assigned = 1'b0;
    for (int t = 0; t < 5; t++) begin
      if (fcode[t] == 5'(`MPO_CODE_FAULT)) begin
        fault_assigned = 1'b1;
      end
    end
  end

  assign step_index = func_active[3:0];

  // unassigned fault input counts as on, so no spurious trip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
    end else if (fault_assigned && !func_active[`MPO_CODE_FAULT]) begin
      fault_q <= 1'b1;
    end else if (func_active[`MPO_CODE_RESET]) begin
      fault_q <= 1'b0;
    end
  end

  assign fault_alarm    = fault_q;
  assign output_shutoff = fault_q || func_active[`MPO_CODE_COAST];

  a_mode_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !(meter_q[0] && board_output_selector_switch) |=> !pulse_meter_output)
    else $error("pulse active outside pulse mode");
  a_relay_pol: assert property (@(posedge pclk) disable iff (!presetn)
    relay_ready_q |-> (relay_contact_a == (trip_q != meter_q[12])))
    else $error("relay polarity wrong");
  a_relay_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (relay_cnt_q < 32'(RELAY_CYCLES - 1)) |=> !relay_ready_q)
    else $error("relay energized early");
  a_fault_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (fault_q && !func_active[7]) |=> fault_q)
    else $error("fault alarm dropped without reset");
  a_slip_std: assert property (@(posedge pclk) disable iff (!presetn)
    (vector_q[0] && vector_q[23:16] == 8'h0) |-> slip_comp_amount == `MPO_SLIP_STD)
    else $error("standard slip not used");
  a_ov_avoid: assert property (@(posedge pclk) disable iff (!presetn)
    overvoltage_avoid |-> (torque_q[25:16] == 10'h0))
    else $error("overvoltage avoidance without zero brake");
  a_tl_range: assert property (@(posedge pclk) disable iff (!presetn)
    (torque_q[9:0] == 10'(`MPO_TL_OFF)) || (torque_q[9:0] >= 10'(`MPO_TL_MIN)
    && torque_q[9:0] <= 10'(`MPO_TL_MAX)))
    else $error("driving limit out of range");
  a_rate_range: assert property (@(posedge pclk) disable iff (!presetn)
    pulse_q[15:0] >= 16'(`MPO_RATE_MIN) && pulse_q[15:0] <= 16'(`MPO_RATE_MAX))
    else $error("rate out of range");
  a_level_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    (level_q != 8'h0) |-> (pif.period == FIXED_PERIOD))
    else $error("level mode period not fixed");
  a_level_range: assert property (@(posedge pclk) disable iff (!presetn)
    pulse_q[23:16] <= 8'(`MPO_LEVEL_MAX))
    else $error("average level out of range");
  a_rate_cap: assert property (@(posedge pclk) disable iff (!presetn)
    (level_q == 8'h0 && mon_sel != 16'h0) |-> (per_wide >= 48'(`MPO_CLK_HZ / 32'(rate_q))))
    else $error("pulse rate above full scale");
  a_duty_cap: assert property (@(posedge pclk) disable iff (!presetn)
    hi_wide <= per_wide)
    else $error("high time longer than period");
  a_item_range: assert property (@(posedge pclk) disable iff (!presetn)
    (meter_q[7:4] <= 4'(`MPO_ITEM_MAX)) && (meter_q[11:8] <= 4'(`MPO_ITEM_MAX)))
    else $error("monitor item out of range");
  a_relay_dead: assert property (@(posedge pclk) disable iff (!presetn)
    !relay_ready_q |-> (!relay_contact_a && relay_contact_b))
    else $error("relay energized before delay");
  a_relay_pair: assert property (@(posedge pclk) disable iff (!presetn)
    relay_contact_b == !relay_contact_a)
    else $error("relay contacts not complementary");
  a_brake_range: assert property (@(posedge pclk) disable iff (!presetn)
    (torque_q[25:16] == 10'(`MPO_TL_OFF)) || (torque_q[25:16] == 10'h0)
    || (torque_q[25:16] >= 10'(`MPO_TL_MIN) && torque_q[25:16] <= 10'(`MPO_TL_MAX)))
    else $error("braking limit out of range");
  a_vector_auto: assert property (@(posedge pclk) disable iff (!presetn)
    vector_q[0] |-> (auto_torque_boost && slip_comp_active))
    else $error("vector control without automatic boost");
  a_slip_written: assert property (@(posedge pclk) disable iff (!presetn)
    (!vector_q[0] || vector_q[23:16] != 8'h0) |-> (slip_comp_amount == vector_q[23:16]))
    else $error("written slip amount not applied");
  a_code_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (digital_input == 5'h00) |-> (func_active == 19'h0))
    else $error("function active with all inputs off");
  a_fault_set: assert property (@(posedge pclk) disable iff (!presetn)
    (fault_assigned && !func_active[`MPO_CODE_FAULT]) |=> fault_q)
    else $error("external fault not latched");
  a_fault_stop: assert property (@(posedge pclk) disable iff (!presetn)
    fault_q |-> output_shutoff)
    else $error("output not shut off on fault");
endmodule // mpo_top

// File: mpo_meter_model.sv
/*
  pulse counter standing on the meter terminal.
  assumes pulse_meter_output is a level registered on pclk.
*/
module mpo_meter_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pulse_meter_output,
  output int        period,
  output int        high_time,
  output int        edges
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt;
  logic last;
  // period from rise to rise, high time from rise to fall
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt       <= 0;
      last      <= 1'b0;
      edges     <= 0;
      period    <= 0;
      high_time <= 0;
    end else begin
      last <= pulse_meter_output;
      cnt  <= cnt + 1;
      if (pulse_meter_output && !last) begin
        period <= cnt;
        cnt    <= 1;
        edges  <= edges + 1;
      end
      if (!pulse_meter_output && last) begin
        high_time <= cnt;
      end
    end
  end
endmodule // mpo_meter_model

// File: mpo_top_test.sv
/*
  self-checking bench: apb tasks, terminal and pulse scenarios.
  assumes mpo_top with zero-wait apb and prdata valid in the access phase.
*/
`include "mpo_defs.svh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp); end end
module mpo_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic        sw, trip_in, pmo, ra, rb, dla, bla, ova, atb, sca, sh, fa;
  logic [15:0] mon_value [0:8];
  logic [4:0]  din;
  logic [7:0]  sla;
  logic [18:0] fact;
  logic [3:0]  sidx;
  logic [31:0] bad [3] = '{32'h0000012B, 32'h00001771, 32'h00C91770};
  int          fails, checked, per, hi, edg, n, e0;

  mpo_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .board_output_selector_switch(sw), .mon_value(mon_value),
    .digital_input(din), .trip_in(trip_in), .pulse_meter_output(pmo),
    .relay_contact_a(ra), .relay_contact_b(rb), .driving_limit_active(dla),
    .braking_limit_active(bla), .overvoltage_avoid(ova), .auto_torque_boost(atb),
    .slip_comp_active(sca), .slip_comp_amount(sla), .func_active(fact),
    .step_index(sidx), .output_shutoff(sh), .fault_alarm(fa));
  mpo_meter_model meter (.pclk(pclk), .presetn(presetn), .pulse_meter_output(pmo),
    .period(per), .high_time(hi), .edges(edg));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // one whole transfer; answer taken at the access edge, then one edge to settle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fails++;
      wrap_up();
    end
    err = pslverr;
    rv  = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK(rv, exp)
  endtask

  task automatic put_in(input logic [4:0] v);
    @(posedge pclk);
    din <= v;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask

  // bounded wait for k more rising pulse edges seen by the counter
  task automatic wait_rise(input int k);
    int m;
    m = 0;
    e0 = edg;
    while (edg < e0 + k && m < 80000) begin
      @(posedge pclk);
      m++;
    end
    if (m >= 80000) begin
      fails++;
      wrap_up();
    end
  endtask

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sw = 1'b0;
    trip_in = 1'b0;
    din = 5'h00;
    for (int i = 0; i < 9; i++) mon_value[i] = 16'h1100 + 16'(i);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`MPO_REG_PULSE, 32'h00000BB8);
    rchk(`MPO_REG_TORQUE, 32'h03E703E7);
    apb(1'b0, 12'h01C, 32'h0);
    `CHK(err, 1'b1)
    tdone("reset");
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, `MPO_REG_METER, {20'h0, 4'(i), 4'(i), 4'h0});
      rchk(`MPO_REG_METER, {20'h0, 4'(i), 4'(i), 4'h0});
      rchk(`MPO_REG_MON, {16'h0, mon_value[i]});
    end
    apb(1'b1, `MPO_REG_METER, 32'h00000900);
    rchk(`MPO_REG_METER, 32'h00000880);
    tdone("items");
    apb(1'b1, `MPO_REG_METER, 32'h00000001);
    apb(1'b0, `MPO_REG_STATUS, 32'h0);
    `CHK(rv[2], 1'b0)
    sw <= 1'b1;
    apb(1'b0, `MPO_REG_STATUS, 32'h0);
    `CHK(rv[2], 1'b1)
    apb(1'b1, `MPO_REG_METER, 32'h00000000);
    apb(1'b0, `MPO_REG_STATUS, 32'h0);
    `CHK(rv[2], 1'b0)
    trip_in <= 1'b1;
    apb(1'b0, `MPO_REG_STATUS, 32'h0);
    `CHK({rv[5], rv[3], ra, rb}, 4'b0101)
    apb(1'b1, `MPO_REG_METER, 32'h00001000);
    `CHK({ra, rb}, 2'b01)
    trip_in <= 1'b0;
    tdone("mode and relay");
    apb(1'b1, `MPO_REG_TORQUE, 32'h00000014);
    `CHK({dla, bla, ova}, 3'b101)
    apb(1'b1, `MPO_REG_TORQUE, 32'h00C803E7);
    `CHK({dla, bla, ova}, 3'b010)
    apb(1'b1, `MPO_REG_TORQUE, 32'h00C80013);
    rchk(`MPO_REG_TORQUE, 32'h00C803E7);
    apb(1'b1, `MPO_REG_VECTOR, 32'h00001001);
    `CHK({atb, sca, sla}, {2'b11, `MPO_SLIP_STD})
    apb(1'b1, `MPO_REG_VECTOR, 32'h00051001);
    `CHK({atb, sca, sla}, 10'h305)
    apb(1'b1, `MPO_REG_VECTOR, 32'h00051000);
    `CHK(atb, 1'b0)
    tdone("torque and vector");
    put_in(5'h01);
    for (int c = 0; c < 19; c++) begin
      apb(1'b1, `MPO_REG_TERM, {7'h0, {5{5'(c)}}});
      `CHK(fact & ~19'h100, (19'h1 << c) & ~19'h100)
    end
    apb(1'b1, `MPO_REG_TERM, 32'h00418820);
    put_in(5'b01010);
    `CHK({sidx, fact[4]}, 5'b10100)
    put_in(5'b11111);
    `CHK({sidx, fact[4]}, 5'b11111)
    apb(1'b1, `MPO_REG_TERM, 32'h005294E8);
    put_in(5'b00011);
    put_in(5'b00001);
    `CHK({fa, sh}, 2'b00)
    put_in(5'b00000);
    `CHK({fa, sh}, 2'b11)
    put_in(5'b00010);
    `CHK({fa, sh}, 2'b11)
    put_in(5'b00001);
    `CHK({fa, sh}, 2'b11)
    put_in(5'b00011);
    put_in(5'b00001);
    `CHK({fa, sh}, 2'b00)
    tdone("terminals");
    apb(1'b1, `MPO_REG_PULSE, 32'h00001770);
    mon_value[0] <= 16'hFFFF;
    apb(1'b1, `MPO_REG_METER, 32'h00000001);
    wait_rise(2);
    `CHK(per inside {[33332:33334]}, 1'b1)
    `CHK(hi inside {[16665:16667]}, 1'b1)
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `MPO_REG_PULSE, bad[i]);
      rchk(`MPO_REG_PULSE, 32'h00001770);
    end
    apb(1'b1, `MPO_REG_PULSE, 32'h00C8012C);
    rchk(`MPO_REG_PULSE, 32'h00C8012C);
    apb(1'b1, `MPO_REG_METER, 32'h00000000);
    apb(1'b1, `MPO_REG_PULSE, 32'h00011770);
    mon_value[0] <= 16'h8000;
    apb(1'b1, `MPO_REG_METER, 32'h00000001);
    wait_rise(1);
    n = 0;
    while (pmo && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000) begin
      fails++;
      wrap_up();
    end
    @(negedge pclk);
    `CHK(hi inside {[748:750]}, 1'b1)
    tdone("pulse");
    wrap_up();
  end
endmodule // mpo_top_test
